// ### hw/flash_driver_control_registers.sv
// control registers and sequencing of the led flash driver
module flash_driver_control_registers
   import flash_pkg::*;
#(
   parameter int unsigned STEP_CYC = DURATION_STEP_CYC,
   parameter logic [7:0] CHIP_ID = 8'hb0 // arbitrary identification value
)
(
   input wire logic core_clk, // core clock, 10 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic link_clk, // serial front end byte clock
   input wire logic link_rst_n, // link domain reset, active low
   input wire logic link_byte_valid, // pulse: byte written by host
   input wire logic link_byte_is_ptr, // byte is the register address
   input wire logic [7:0] link_byte, // written byte
   input wire logic link_read_req, // pulse: host reads one byte
   output logic link_read_valid, // pulse: read byte ready
   output logic [7:0] link_read_data, // read byte
   output logic link_busy, // previous request still in flight
   input wire logic strobe_pin, // strobe trigger pin
   input wire logic mask_torch_pin, // mask / torch pin
   input wire logic vin_below_run, // comparator: supply under run level
   input wire logic vin_below_start, // comparator: under start level
   input wire logic strobe_enable, // flash waits for the strobe pin
   input wire logic strobe_level_type, // strobe level sets duration
   input wire logic [3:0] pwm_duty, // indicator duty, (n+1)/16
   input wire logic fault_uvlo_clear, // pulse: clear undervoltage flag
   output logic [7:0] sink_current_code, // current code to the sinks
   output logic current_sink_outputs, // sinks enabled
   output logic [1:0] inductor_peak_limit, // boost coil limit code
   output logic const_voltage_mode, // boost in fixed output mode
   output logic [2:0] run_threshold_code, // run comparator level
   output logic [2:0] start_threshold_code, // start comparator level
   output logic fault_uvlo, // undervoltage fault, sticky
   output logic flash_active // flash pulse in progress
);

   // =====================================================================
   // link side crossings
   logic req_busy;
   logic req_valid;
   logic [9:0] req_data;
   logic resp_valid_r;
   logic [7:0] resp_data_r;
   logic rd_pending_r;

   cdc_word #(.W(10)) u_req (
      .src_clk(link_clk),
      .src_rst_n(link_rst_n),
      .src_valid(link_byte_valid | link_read_req),
      .src_data({link_read_req, link_byte_is_ptr, link_byte}),
      .src_busy(req_busy),
      .dst_clk(core_clk),
      .dst_rst_n(rst_n),
      .dst_valid(req_valid),
      .dst_data(req_data)
   );

   cdc_word #(.W(8)) u_resp (
      .src_clk(core_clk),
      .src_rst_n(rst_n),
      .src_valid(resp_valid_r),
      .src_data(resp_data_r),
      .src_busy(),
      .dst_clk(link_clk),
      .dst_rst_n(link_rst_n),
      .dst_valid(link_read_valid),
      .dst_data(link_read_data)
   );

   always_ff @(posedge link_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
         rd_pending_r <= 1'b0;
      else if (link_read_req)
         rd_pending_r <= 1'b1;
      else if (link_read_valid)
         rd_pending_r <= 1'b0;
   end

   assign link_busy = req_busy | rd_pending_r;

   // =====================================================================
   // pin synchronisers
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic strobe_prev_r;
   logic strobe_s;
   logic mask_s;
   logic below_run_s;
   logic below_start_s;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         strobe_prev_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= {strobe_pin, mask_torch_pin, vin_below_run,
                      vin_below_start};
         pin_s2_r <= pin_s1_r;
         strobe_prev_r <= pin_s2_r[3];
      end
   end

   assign strobe_s = pin_s2_r[3];
   assign mask_s = pin_s2_r[2];
   assign below_run_s = pin_s2_r[1];
   assign below_start_s = pin_s2_r[0];

   // =====================================================================
   // register file
   logic [7:0] ptr_r;
   logic [7:0] led_current_level_r;
   logic [7:0] led_current_copy_r;
   logic [7:0] pa_mask_config_r;
   logic [7:0] supply_droop_config_r;
   logic [7:0] pulse_duration_r;
   logic [1:0] mode_r;
   logic out_on_r;
   logic auto_clear;
   logic wr_en;
   logic rd_en;
   logic [7:0] rd_mux;

   assign wr_en = req_valid && !req_data[9] && !req_data[8];
   assign rd_en = req_valid && req_data[9];

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ptr_r <= 8'h00;
      else if (req_valid && req_data[8] && !req_data[9])
         ptr_r <= req_data[7:0];
      else if (wr_en || rd_en)
         ptr_r <= ptr_r + 8'h01;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         led_current_level_r <= RST_LED_CURRENT_LEVEL;
         led_current_copy_r <= RST_LED_CURRENT_LEVEL;
         pa_mask_config_r <= RST_PA_MASK_CONFIG;
         supply_droop_config_r <= RST_SUPPLY_DROOP_CONFIG;
         pulse_duration_r <= RST_PULSE_DURATION;
      end
      else if (wr_en)
      begin
         unique case (ptr_r)
            OFS_LED_CURRENT_LEVEL: led_current_level_r <= req_data[7:0];
            OFS_LED_CURRENT_COPY: led_current_copy_r <= req_data[7:0];
            OFS_PA_MASK_CONFIG: pa_mask_config_r <= req_data[7:0];
            OFS_SUPPLY_DROOP_CONFIG: supply_droop_config_r <= req_data[7:0];
            OFS_PULSE_DURATION: pulse_duration_r <= req_data[7:0];
            default: ;
         endcase
      end
   end

   // a host write in the same cycle as the auto-clear wins
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r <= MODE_SHUTDOWN;
         out_on_r <= 1'b0;
      end
      else if (wr_en && ptr_r == OFS_OPERATING_CONTROL)
      begin
         mode_r <= req_data[MODE_LSB +: 2];
         out_on_r <= req_data[OUT_ON_BIT];
      end
      else if (auto_clear)
      begin
         mode_r <= MODE_SHUTDOWN;
         out_on_r <= 1'b0;
      end
   end

   // reserved control bit is not stored and reads as zero
   always_comb
   begin
      unique case (ptr_r)
         OFS_CHIP_ID: rd_mux = CHIP_ID;
         OFS_LED_CURRENT_LEVEL: rd_mux = led_current_level_r;
         OFS_LED_CURRENT_COPY: rd_mux = led_current_copy_r;
         OFS_PA_MASK_CONFIG: rd_mux = pa_mask_config_r;
         OFS_SUPPLY_DROOP_CONFIG: rd_mux = supply_droop_config_r;
         OFS_PULSE_DURATION: rd_mux = pulse_duration_r;
         OFS_OPERATING_CONTROL: rd_mux = {4'h0, out_on_r, 1'b0, mode_r};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resp_valid_r <= 1'b0;
         resp_data_r <= 8'h00;
      end
      else
      begin
         resp_valid_r <= rd_en;
         if (rd_en)
            resp_data_r <= rd_mux;
      end
   end

   // =====================================================================
   // flash sequencing
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_FLASH = 3'b100
   } flash_state_e;

   flash_state_e state_r;
   logic out_on_prev_r;
   logic use_mask_r;
   logic timer_start;
   logic timer_expired;
   logic begin_flash;
   logic [1:0] pin_mode;
   logic [2:0] start_thr;
   logic start_fail;
   logic uv_shutdown;

   assign pin_mode = pa_mask_config_r[PIN_MODE_LSB +: 2];
   assign start_thr = supply_droop_config_r[START_THR_LSB +: 3];
   assign uv_shutdown = supply_droop_config_r[UV_SHUTDOWN_BIT];
   assign begin_flash = out_on_r && !out_on_prev_r && mode_r == MODE_FLASH;
   assign start_fail = begin_flash && start_thr != 3'h0
                       && below_start_s;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         out_on_prev_r <= 1'b0;
      else
         out_on_prev_r <= out_on_r;
   end

   flash_timer #(.STEP_CYC(STEP_CYC)) u_timer (
      .clk(core_clk),
      .rst_n(rst_n),
      .start(timer_start),
      .stop(auto_clear),
      .code(pulse_duration_r),
      .expired(timer_expired)
   );

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         use_mask_r <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
               if (begin_flash && !(start_fail && uv_shutdown))
               begin
                  use_mask_r <= start_fail;
                  state_r <= strobe_enable ? ST_ARMED : ST_FLASH;
               end
            ST_ARMED:
               if (out_on_r == 1'b0 || mode_r != MODE_FLASH)
                  state_r <= ST_IDLE;
               else if (strobe_level_type ? strobe_s
                        : (strobe_s && !strobe_prev_r))
                  state_r <= ST_FLASH;
            ST_FLASH:
               if (auto_clear)
                  state_r <= ST_IDLE;
         endcase
      end
   end

   // timer runs from the moment the light goes on
   assign timer_start = (state_r == ST_IDLE && begin_flash
                         && !(start_fail && uv_shutdown) && !strobe_enable)
                        || (state_r == ST_ARMED && out_on_r
                            && mode_r == MODE_FLASH
                            && (strobe_level_type ? strobe_s
                                : (strobe_s && !strobe_prev_r)));

   // pulse ends on timeout, on strobe release in level mode, or on a refused start
   assign auto_clear = (state_r == ST_FLASH && timer_expired)
                       || (state_r == ST_FLASH && strobe_enable
                           && strobe_level_type && !strobe_s)
                       || (state_r == ST_IDLE && start_fail
                           && uv_shutdown);
   assign flash_active = state_r == ST_FLASH;

   // =====================================================================
   // current selection, ramp and droop control
   logic [PRESCALE_W-1:0] pwm_cnt_r;
   logic pwm_on;
   logic tick;
   logic [7:0] target;
   logic sinks_on;
   logic [7:0] ramp_r;
   logic [2:0] run_thr;
   logic droop;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwm_cnt_r <= '0;
      else if (pwm_cnt_r == PRESCALE_W'(PWM_CYC - 1))
         pwm_cnt_r <= '0;
      else
         pwm_cnt_r <= pwm_cnt_r + 16'h0001;
   end

   assign tick = pwm_cnt_r == '0;
   // duty in sixteenths of the 32 us period
   assign pwm_on = pwm_cnt_r < PRESCALE_W'(({12'h000, pwm_duty} + 16'h0001)
                   * PRESCALE_W'(PWM_CYC / 16));

   always_comb
   begin
      target = 8'h00;
      sinks_on = 1'b0;
      if (mode_r == MODE_FLASH && flash_active)
      begin
         sinks_on = out_on_r;
         if (use_mask_r || (pin_mode == PIN_PA_MASK && mask_s))
            target = {pa_mask_config_r[MASK_CURRENT_LSB +: 4], 4'h0};
         else
            target = led_current_level_r;
      end
      else if (mode_r == MODE_INDICATOR)
      begin
         sinks_on = out_on_r && pwm_on;
         target = {2'h0, led_current_level_r[5:0]};
      end
      else if (mode_r == MODE_ASSIST)
      begin
         sinks_on = out_on_r;
         target = {1'h0, led_current_level_r[6:0]};
      end
      else if (mode_r == MODE_SHUTDOWN && pin_mode == PIN_EXT_TORCH
               && mask_s)
      begin
         sinks_on = 1'b1;
         target = {1'h0, led_current_level_r[6:0]};
      end
   end

   assign run_thr = supply_droop_config_r[RUN_THR_LSB +: 3];
   assign droop = flash_active && run_thr != 3'h0 && below_run_s;

   // flash current ramps one step per pwm period; droop halts and lowers it
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_r <= 8'h00;
      else if (!flash_active)
         ramp_r <= 8'h00;
      else if (tick && droop)
         ramp_r <= (ramp_r == 8'h00) ? 8'h00 : ramp_r - 8'h01;
      else if (tick && ramp_r < target)
         ramp_r <= ramp_r + 8'h01;
      else if (ramp_r > target)
         ramp_r <= target;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sink_current_code <= 8'h00;
         current_sink_outputs <= 1'b0;
      end
      else
      begin
         current_sink_outputs <= sinks_on;
         if (!sinks_on)
            sink_current_code <= 8'h00;
         else
            sink_current_code <= flash_active ? ramp_r : target;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_uvlo <= 1'b0;
      else if (droop || start_fail)
         fault_uvlo <= 1'b1;
      else if (fault_uvlo_clear)
         fault_uvlo <= 1'b0;
   end

   assign inductor_peak_limit = pa_mask_config_r[COIL_LIMIT_LSB +: 2];
   assign const_voltage_mode = supply_droop_config_r[CONST_V_BIT];
   assign run_threshold_code = run_thr;
   assign start_threshold_code = start_thr;

endmodule : flash_driver_control_registers

// ### hw/flash_pkg.sv
// constants and helpers shared by the flash driver control logic
package flash_pkg;

   // =====================================================================
   // register offsets
   localparam logic [7:0] OFS_CHIP_ID = 8'h00;
   localparam logic [7:0] OFS_LED_CURRENT_LEVEL = 8'h01;
   localparam logic [7:0] OFS_LED_CURRENT_COPY = 8'h02;
   localparam logic [7:0] OFS_PA_MASK_CONFIG = 8'h03;
   localparam logic [7:0] OFS_SUPPLY_DROOP_CONFIG = 8'h04;
   localparam logic [7:0] OFS_PULSE_DURATION = 8'h05;
   localparam logic [7:0] OFS_OPERATING_CONTROL = 8'h06;

   // =====================================================================
   // values after reset
   localparam logic [7:0] RST_LED_CURRENT_LEVEL = 8'h9c;
   localparam logic [7:0] RST_PA_MASK_CONFIG = 8'h68;
   localparam logic [7:0] RST_SUPPLY_DROOP_CONFIG = 8'h2c;
   localparam logic [7:0] RST_PULSE_DURATION = 8'h23;
   localparam logic [7:0] RST_OPERATING_CONTROL = 8'h00;

   // =====================================================================
   // field positions
   localparam int PIN_MODE_LSB = 0;
   localparam int COIL_LIMIT_LSB = 2;
   localparam int MASK_CURRENT_LSB = 4;
   localparam int RUN_THR_LSB = 0;
   localparam int START_THR_LSB = 3;
   localparam int UV_SHUTDOWN_BIT = 6;
   localparam int CONST_V_BIT = 7;
   localparam int MODE_LSB = 0;
   localparam int RESERVED_BIT = 2;
   localparam int OUT_ON_BIT = 3;

   // =====================================================================
   // encodings
   localparam logic [1:0] PIN_IGNORED = 2'h0;
   localparam logic [1:0] PIN_PA_MASK = 2'h1;
   localparam logic [1:0] PIN_EXT_TORCH = 2'h2;
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_INDICATOR = 2'h1;
   localparam logic [1:0] MODE_ASSIST = 2'h2;
   localparam logic [1:0] MODE_FLASH = 2'h3;
   localparam logic [7:0] DURATION_COARSE = 8'h80;

   // =====================================================================
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLK_FREQ_KHZ = 10000;
   localparam int PWM_PERIOD_NS = 32000;
   localparam int PWM_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DURATION_STEP_MS = 2;
   localparam int DURATION_STEP_CYC = DURATION_STEP_MS * CLK_FREQ_KHZ;
   localparam int COARSE_STEP_UNITS = 4;
   localparam int FINE_UNITS_TOTAL = 128;
   localparam int PRESCALE_W = 16;
   localparam int UNITS_W = 10;

   // duration in 2 ms units: fine codes give code+1, coarse codes 8 ms steps
   function automatic logic [UNITS_W-1:0] timeout_units(
      input logic [7:0] code);
      logic [UNITS_W-1:0] c;
      c = {2'h0, code};
      if (code < DURATION_COARSE)
         timeout_units = c + 10'h001;
      else
         timeout_units = ((c - 10'h07f) << 2) + 10'h080;
   endfunction : timeout_units

endpackage : flash_pkg

// ### hw/cdc_word.sv
// toggle handshake carrying one word between two clock domains
module cdc_word
   import flash_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic src_clk, // source clock
   input wire logic src_rst_n, // source reset, async low
   input wire logic src_valid, // one-cycle request
   input wire logic [W-1:0] src_data, // word sampled with src_valid
   output logic src_busy, // word still in flight
   input wire logic dst_clk, // destination clock
   input wire logic dst_rst_n, // destination reset, async low
   output logic dst_valid, // one-cycle arrival pulse
   output logic [W-1:0] dst_data // word, held until next arrival
);

   // =====================================================================
   // source side
   logic req_r;
   logic [W-1:0] hold_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic req_s1_r;
   logic req_s2_r;
   logic ack_r;

   always_ff @(posedge src_clk or negedge src_rst_n)
   begin
      if (!src_rst_n)
      begin
         req_r <= 1'b0;
         hold_r <= '0;
      end
      else if (src_valid && !src_busy)
      begin
         req_r <= ~req_r;
         hold_r <= src_data;
      end
   end

   always_ff @(posedge src_clk or negedge src_rst_n)
   begin
      if (!src_rst_n)
      begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end
      else
      begin
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   assign src_busy = req_r ^ ack_s2_r;

   // =====================================================================
   // destination side; hold_r is stable once the toggle is seen

   always_ff @(posedge dst_clk or negedge dst_rst_n)
   begin
      if (!dst_rst_n)
      begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         ack_r <= 1'b0;
         dst_valid <= 1'b0;
         dst_data <= '0;
      end
      else
      begin
         req_s1_r <= req_r;
         req_s2_r <= req_s1_r;
         ack_r <= req_s2_r;
         dst_valid <= req_s2_r ^ ack_r;
         if (req_s2_r ^ ack_r)
            dst_data <= hold_r;
      end
   end

endmodule : cdc_word

// ### hw/flash_timer.sv
// flash duration and timeout counter in 2 ms units
module flash_timer
   import flash_pkg::*;
#(
   parameter int unsigned STEP_CYC = DURATION_STEP_CYC
)
(
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic start, // pulse: load and run
   input wire logic stop, // pulse: abandon count
   input wire logic [7:0] code, // duration code
   output logic expired // pulse when the duration is used up
);

   logic [PRESCALE_W-1:0] pre_r;
   logic [UNITS_W-1:0] units_r;
   logic run_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_r <= '0;
         units_r <= '0;
         run_r <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (start)
         begin
            pre_r <= '0;
            units_r <= timeout_units(code);
            run_r <= 1'b1;
         end
         else if (stop)
            run_r <= 1'b0;
         else if (run_r)
         begin
            if (pre_r == PRESCALE_W'(STEP_CYC - 1))
            begin
               pre_r <= '0;
               units_r <= units_r - 10'h001;
               if (units_r == 10'h001)
               begin
                  run_r <= 1'b0;
                  expired <= 1'b1;
               end
            end
            else
               pre_r <= pre_r + 16'h0001;
         end
      end
   end

endmodule : flash_timer

// ### bench/flash_monitor.sv
// port assertions for the flash driver control registers
module flash_monitor
#(parameter int unsigned STEP_CYC = 20)
(
   input wire logic core_clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic [1:0] inductor_peak_limit, // coil limit code
   input wire logic [2:0] run_threshold_code, // run level
   input wire logic [2:0] start_threshold_code, // start level
   input wire logic vin_below_run, // supply comparator pin
   input wire logic fault_uvlo_clear, // flag clear pulse
   input wire logic fault_uvlo, // sticky fault
   input wire logic flash_active, // flash in progress
   input wire logic current_sink_outputs, // sinks enabled
   input wire logic [7:0] sink_current_code // sink code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==============================
   // flash length, longest code is 640 units
   int flash_cyc_r;
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         flash_cyc_r <= 0;
      else
         flash_cyc_r <= flash_active ? flash_cyc_r + 1 : 0;
   sequence droop_s;
      (flash_active && run_threshold_code != 3'h0 && vin_below_run) [*4];
   endsequence
   chk_coil_reset: assert property ($rose(rst_n) |->
      inductor_peak_limit == 2'h2) else $error("coil reset");
   chk_thr_reset: assert property ($rose(rst_n) |->
      run_threshold_code == 3'h4 && start_threshold_code == 3'h5)
      else $error("threshold reset");
   chk_fault_sticky: assert property (fault_uvlo && !fault_uvlo_clear
      |=> fault_uvlo) else $error("fault dropped");
   chk_droop_flag: assert property (droop_s |-> ##[0:3] fault_uvlo)
      else $error("droop not flagged");
   chk_timeout_cap: assert property (flash_cyc_r <= 640 * STEP_CYC + 4)
      else $error("flash too long");
   chk_sinks_on: assert property ($rose(flash_active) |->
      ##[0:3] current_sink_outputs) else $error("sinks off");
   chk_flash_off: assert property ($fell(flash_active) |->
      ##[0:3] sink_current_code == 8'h00) else $error("current left on");
   chk_ramp_step: assert property (flash_active [*3] |->
      {1'b0, sink_current_code} <= {1'b0, $past(sink_current_code)} + 9'h001)
      else $error("ramp jump");
endmodule : flash_monitor

bind flash_driver_control_registers flash_monitor #(.STEP_CYC(STEP_CYC))
   mon_u (.*);

// ### bench/link_host.sv
// host side of the register link, one byte request at a time
module link_host
(
   input wire logic link_clk, // byte clock
   input wire logic link_busy, // request in flight
   input wire logic link_read_valid, // read byte ready
   input wire logic [7:0] link_read_data, // read byte
   output logic link_byte_valid = 1'b0, // write strobe
   output logic link_byte_is_ptr = 1'b0, // byte is address
   output logic [7:0] link_byte = 8'h00, // written byte
   output logic link_read_req = 1'b0 // read strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // request held until the edge that takes it
   task automatic xfer(input logic rd, p, input logic [7:0] b,
      output logic [7:0] q);
      int n = 0;
      do
         @(posedge link_clk);
      while (link_busy && ++n < 64);
      {link_read_req, link_byte_valid, link_byte_is_ptr} <= {rd, !rd, p};
      link_byte <= b;
      @(posedge link_clk);
      {link_read_req, link_byte_valid} <= 2'b00;
      link_byte <= ~b; // released byte must not look valid
      while (rd && !link_read_valid && ++n < 64)
         @(posedge link_clk);
      q = link_read_data;
   endtask : xfer
endmodule : link_host

// ### bench/flash_driver_control_registers_test.sv
// self-checking bench for the flash driver control registers
module flash_driver_control_registers_test
   import flash_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID = 8'h5a; // arbitrary value
   logic core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic mask_torch_pin = 1'b0, vin_below_run = 1'b0;
   logic vin_below_start = 1'b0, fault_uvlo_clear = 1'b0;
   logic [3:0] pwm_duty = 4'h7;
   logic [15:0] lfsr = 16'd46013;
   logic [7:0] q, v;
   int n_fail = 0, checks_done = 0, cyc = 0, d, e;
   int mdl[8] = '{ID, 8'h9c, 8'h9c, 8'h68, 8'h2c, 8'h23, 8'h00, 8'h00};
   logic [7:0] codes[3] = '{8'h00, 8'h7f, 8'h81};
   logic strobe_pin = 1'b0, strobe_enable = 1'b0, strobe_level_type = 1'b0;
   wire logic link_byte_valid, link_byte_is_ptr, link_read_req;
   wire logic link_busy, link_read_valid, flash_active, fault_uvlo;
   wire logic current_sink_outputs, const_voltage_mode;
   wire logic [7:0] link_byte, link_read_data, sink_current_code;
   wire logic [1:0] inductor_peak_limit;
   wire logic [2:0] run_threshold_code, start_threshold_code;
   flash_driver_control_registers #(.STEP_CYC(20), .CHIP_ID(ID)) dut_u (.*,
      .link_rst_n(rst_n));
   link_host host_u (.*);
   initial forever #50 core_clk = ~core_clk;
   initial
   begin
      #7;
      forever #32 link_clk = ~link_clk;
   end
   always @(posedge core_clk)
      if (++cyc > 40000)
      begin
         n_fail++;
         finish_test();
      end
   // ==============================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] b);
      host_u.xfer(1'b0, 1'b1, a, q);
      host_u.xfer(1'b0, 1'b0, b, q);
      mdl[a] = (a == 8'h06) ? b & 8'h0b : b;
   endtask : wr
   task automatic read_all();
      host_u.xfer(1'b0, 1'b1, 8'h00, q);
      for (int i = 0; i < 8; i++)
      begin
         host_u.xfer(1'b1, 1'b0, 8'h00, q);
         chk(q, mdl[i][7:0]);
      end
   endtask : read_all
   task automatic run_flash();
      wr(8'h06, 8'h0b);
      d = 0;
      repeat (40)
         if (!flash_active)
            @(posedge core_clk);
      while (flash_active && d < 30000)
      begin
         @(posedge core_clk);
         d++;
      end
      mdl[6] = 0; // auto-clear
   endtask : run_flash
   task automatic finish_test();
      if (n_fail == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      read_all();
      host_u.xfer(1'b0, 1'b1, 8'h01, q);
      for (int i = 1; i < 6; i++)
      begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         v = (i == 2) ? mdl[1][7:0] : lfsr[7:0];
         v[1:0] = (i == 3) ? 2'h0 : v[1:0];
         pwm_duty <= lfsr[11:8];
         host_u.xfer(1'b0, 1'b0, v, q);
         mdl[i] = v;
      end
      read_all();
      chk({inductor_peak_limit, const_voltage_mode}, {mdl[3][3:2], mdl[4][7]});
      chk({start_threshold_code, run_threshold_code}, mdl[4][5:0]);
      wr(8'h04, 8'h00);
      foreach (codes[k])
      begin
         wr(8'h05, codes[k]);
         run_flash();
         e = 20 * (codes[k] < 8'h80 ? codes[k] + 1 : codes[k] * 4 - 380);
         chk(d >= e - 3 && d <= e + 3, 1'b1);
      end
      vin_below_start <= 1'b1;
      wr(8'h04, 8'h48);
      run_flash();
      chk({d[14:0], fault_uvlo}, 16'h0001);
      read_all();
      @(posedge core_clk);
      {vin_below_start, fault_uvlo_clear} <= 2'b01;
      @(posedge core_clk);
      fault_uvlo_clear <= 1'b0;
      @(posedge core_clk);
      chk(fault_uvlo, 1'b0);
      wr(8'h04, 8'h01);
      vin_below_run <= 1'b1;
      run_flash();
      chk(fault_uvlo, 1'b1);
      vin_below_run <= 1'b0;
      {strobe_pin, strobe_enable, strobe_level_type} <= 3'h7;
      run_flash();
      chk(d >= 2718 && d <= 2724, 1'b1);
      {strobe_pin, strobe_level_type} <= 2'h0;
      wr(8'h06, 8'h0b);
      repeat (40) @(posedge core_clk);
      chk(flash_active, 1'b0);
      strobe_pin <= 1'b1;
      repeat (40)
         if (!flash_active)
            @(posedge core_clk);
      chk(flash_active, 1'b1);
      repeat (3000)
         if (flash_active)
            @(posedge core_clk);
      chk(flash_active, 1'b0);
      {strobe_pin, strobe_enable} <= 2'h0;
      wr(8'h01, 8'hff);
      wr(8'h02, 8'hff);
      for (int k = 0; k < 3; k++)
      begin
         wr(8'h03, k == 2 ? 8'h02 : 8'h00);
         mask_torch_pin <= (k == 2);
         wr(8'h06, k == 0 ? 8'h09 : k == 1 ? 8'h0a : 8'h00);
         repeat (400)
            if (!current_sink_outputs)
               @(posedge core_clk);
         chk(sink_current_code, k == 0 ? 8'h3f : 8'h7f);
         wr(8'h06, 8'h00);
         mask_torch_pin <= 1'b0;
      end
      finish_test();
   end
endmodule : flash_driver_control_registers_test
